//--- hw/tsos_scheduler.v
// timestamped output scheduler: output-area image, entry acceptance,
// 31-deep entry queue, microsecond ticker and four scheduled channels.
// assumes the writer fills the image byte by byte then pulses commit_i.
`default_nettype none
`include "tsos_regs.vh"

module tsos_scheduler (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire large_area_i,
    input wire run_i,
    input wire wr_en_i,
    input wire [5:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    input wire commit_i,
    output reg busy_o,
    output reg [3:0] chan_o,
    output reg [7:0] last_seq_o,
    output reg [7:0] next_seq_o,
    output reg [7:0] queue_state_o,
    output reg [7:0] queue_count_o,
    output reg [31:0] ticker_o
);

    // one-hot scan states and the microsecond prescaler end count
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SCAN = 2'b10;
    localparam [6:0] TICK_LAST = `TSOS_TICK_LAST;

    // sequence successor modulo 64
    function [5:0] seq_succ;
        input [5:0] s;
        begin
            seq_succ = (s == `TSOS_SEQ_MAX) ? `TSOS_SEQ_RESET : s + 6'h01;
        end
    endfunction

    // byte address of a field inside a slot
    function [5:0] slot_addr;
        input [3:0] slot;
        input [1:0] field;
        begin
            slot_addr = {slot, field};
        end
    endfunction

    // queue ring pointer successor; the ring holds QMAX entries
    function [4:0] ptr_succ;
        input [4:0] p;
        begin
            ptr_succ = (p == `TSOS_QMAX - 6'h01) ? 5'h00 : p + 5'h01;
        end
    endfunction

    // output area image as written by the controlling side
    // no reset: slots read as unknown until the writer fills them
    reg [7:0] image [0:`TSOS_AREA_BYTES-1];

    // queued entries: state, sequence with final flag, apply time
    reg [3:0] q_state [0:`TSOS_QDEPTH-1];
    reg [6:0] q_seq [0:`TSOS_QDEPTH-1];
    reg [15:0] q_time [0:`TSOS_QDEPTH-1];

    // scan state, queue ring pointers and bookkeeping counters
    reg [1:0] state;
    reg [3:0] scan_idx;
    reg scan_took;
    reg [4:0] wr_ptr;
    reg [4:0] rd_ptr;
    reg [5:0] count;
    reg [5:0] flag_count;
    reg [5:0] last_seq;
    reg [7:0] state_code;
    reg [6:0] prescale;
    reg run_q;
    reg stale;

    // combinational views of the slot under scan and of the queue head
    wire [3:0] slot_limit;
    wire [7:0] cur_state;
    wire [7:0] cur_seq;
    wire [15:0] cur_time;
    wire [5:0] expect_seq;
    wire q_full;
    wire q_empty;
    wire pop;
    wire push;
    wire push_flag;
    wire pop_flag;
    wire scan_stop;
    wire seq_follows;

    assign slot_limit = large_area_i ? `TSOS_SLOTS_LARGE : `TSOS_SLOTS_SMALL;
    assign cur_state = image[slot_addr(scan_idx, `TSOS_ENT_STATE)];
    assign cur_seq = image[slot_addr(scan_idx, `TSOS_ENT_SEQ)];
    assign cur_time = {image[slot_addr(scan_idx, `TSOS_ENT_TIME_HI)],
                       image[slot_addr(scan_idx, `TSOS_ENT_TIME_LO)]};
    assign expect_seq = seq_succ(last_seq);
    // sequence number is the successor of the last accepted one
    assign seq_follows = (cur_seq[`TSOS_SEQ_MSB:0] == expect_seq);
    assign q_full = (count == `TSOS_QMAX);
    assign q_empty = (count == 6'h00);
    // an entry is pushed only when it follows the last accepted number
    assign push = (state == ST_SCAN) && !q_full && seq_follows;
    assign push_flag = push && cur_seq[`TSOS_SEQ_LAST_BIT];
    // head entry fires when the ticker low word equals its time
    // entries sharing one apply time leave on consecutive cycles
    assign pop = !q_empty && (ticker_o[15:0] == q_time[rd_ptr]);
    assign pop_flag = pop && q_seq[rd_ptr][`TSOS_SEQ_LAST_BIT];
    // scanning ends at a refused slot, a final-flag slot or the area end
    assign scan_stop = !push || cur_seq[`TSOS_SEQ_LAST_BIT] ||
                       (scan_idx == slot_limit - 4'h1);

    // image write port, frozen while a scan reads it
    always @(posedge clk_i) begin
        if (ce_i && wr_en_i && state == ST_IDLE &&
            wr_addr_i < `TSOS_AREA_BYTES) begin
            image[wr_addr_i] <= wr_data_i;
        end
    end

    // queue storage has no reset; only pointers and counts define content
    // pop reads the head slot while push writes the tail slot
    always @(posedge clk_i) begin
        if (ce_i && push) begin
            q_state[wr_ptr] <= cur_state[`TSOS_STATE_CH0:`TSOS_STATE_CH3];
            q_seq[wr_ptr] <= cur_seq[`TSOS_SEQ_LAST_BIT:0];
            q_time[wr_ptr] <= cur_time;
        end
    end

    // microsecond ticker: prescaler of whole clock cycles per microsecond
    // the step length assumes the fixed 10 ns clock; another clock needs new constants
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            prescale <= 7'h00;
            ticker_o <= 32'h00000000;
        end else if (ce_i) begin
            if (prescale == TICK_LAST) begin
                prescale <= 7'h00;
                ticker_o <= ticker_o + 32'h00000001; // wraps naturally
            end else begin
                prescale <= prescale + 7'h01;
            end
        end
    end

    // scan control: one slot examined per clock
    // a refused slot ends the scan so no later slot can overtake it
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            scan_idx <= 4'h0;
            scan_took <= 1'b0;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (commit_i) begin
                        state <= ST_SCAN;
                        scan_idx <= 4'h0;
                        scan_took <= 1'b0;
                        busy_o <= 1'b1;
                    end
                end
                ST_SCAN: begin
                    if (push) begin
                        scan_took <= 1'b1;
                    end
                    if (scan_stop) begin
                        state <= ST_IDLE;
                        busy_o <= 1'b0;
                    end else begin
                        scan_idx <= scan_idx + 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

    // queue pointers, counts and last accepted number
    // count moves only when exactly one of push and pop happens, flag_count when exactly one of push_flag and pop_flag
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= 5'h00;
            rd_ptr <= 5'h00;
            count <= 6'h00;
            flag_count <= 6'h00;
            last_seq <= `TSOS_SEQ_RESET; // first expected entry is 1
        end else if (ce_i) begin
            if (push) begin
                wr_ptr <= ptr_succ(wr_ptr);
                last_seq <= cur_seq[`TSOS_SEQ_MSB:0];
            end
            if (pop) begin
                rd_ptr <= ptr_succ(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 6'h01;
            end else if (pop && !push) begin
                count <= count - 6'h01;
            end
            if (push_flag && !pop_flag) begin
                flag_count <= flag_count + 6'h01;
            end else if (pop_flag && !push_flag) begin
                flag_count <= flag_count - 6'h01;
            end
        end
    end

    // queue state code, settled when a scan ends
    // a full stop overrides entries already stored in the same scan
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_code <= `TSOS_QS_NONE;
        end else if (ce_i && state == ST_SCAN && scan_stop) begin
            if (push) begin
                state_code <= `TSOS_QS_OK;
            end else if (q_full && seq_follows) begin
                state_code <= `TSOS_QS_FULL;
            end else if (scan_took) begin
                state_code <= `TSOS_QS_OK; // later slots simply not new
            end else if (cur_seq[`TSOS_SEQ_MSB:0] == last_seq) begin
                state_code <= `TSOS_QS_NONE; // same image sent again
            end else begin
                state_code <= `TSOS_QS_MISMATCH;
            end
        end
    end

    // halt-to-run marks the pending-side status stale until an entry lands
    // run_q resets low, so a reset taken while running reads as a fresh start
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
            stale <= 1'b0;
        end else if (ce_i) begin
            run_q <= run_i;
            if (push) begin
                stale <= 1'b0; // acceptance wins over a new transition
            end else if (run_i && !run_q) begin
                stale <= 1'b1;
            end
        end
    end

    // channel drivers hold their value between apply events
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            chan_o <= 4'h0;
        end else if (ce_i && pop) begin
            chan_o <= q_state[rd_ptr];
        end
    end

    // status bytes of the input area; while stale the next/count bytes freeze,
    // which is the cheapest way to be honest that they are not trustworthy
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            last_seq_o <= {`TSOS_LASTSEQ_TAG, `TSOS_SEQ_RESET};
            next_seq_o <= {`TSOS_NEXTSEQ_TAG, `TSOS_SEQ_FIRST};
            queue_state_o <= `TSOS_QS_NONE;
            queue_count_o <= 8'h00;
        end else if (ce_i) begin
            last_seq_o <= {`TSOS_LASTSEQ_TAG, last_seq};
            queue_state_o <= (flag_count != 6'h00) ?
                             (state_code | `TSOS_QS_LASTFLAG) : state_code;
            if (!stale) begin
                next_seq_o <= {`TSOS_NEXTSEQ_TAG,
                               q_empty ? expect_seq : q_seq[rd_ptr][`TSOS_SEQ_MSB:0]};
                queue_count_o <= {2'h0, count};
            end
        end
    end

endmodule // tsos_scheduler
`default_nettype wire

//--- hw/tsos_regs.vh
// constants for the timestamped output scheduler: layout, codes, timing
// assumes inclusion by tsos_scheduler.v only
`ifndef TSOS_REGS_VH
`define TSOS_REGS_VH

// entry layout inside the output area, four bytes per slot
`define TSOS_ENT_STATE 2'h0
`define TSOS_ENT_SEQ 2'h1
`define TSOS_ENT_TIME_LO 2'h2
`define TSOS_ENT_TIME_HI 2'h3
`define TSOS_AREA_BYTES 60
`define TSOS_SLOTS_SMALL 4'h5
`define TSOS_SLOTS_LARGE 4'hF

// output state byte: channel 0 on bit 7 down to channel 3 on bit 4
`define TSOS_STATE_CH0 7
`define TSOS_STATE_CH3 4

// sequence number byte fields
`define TSOS_SEQ_MSB 5
`define TSOS_SEQ_LAST_BIT 6
`define TSOS_SEQ_FIRST 6'h01
`define TSOS_SEQ_RESET 6'h00
`define TSOS_SEQ_MAX 6'h3F

// queue storage
`define TSOS_QDEPTH 32
`define TSOS_QMAX 6'h1F

// queue state codes and the flag ORed in
`define TSOS_QS_OK 8'h00
`define TSOS_QS_MISMATCH 8'h01
`define TSOS_QS_NONE 8'h02
`define TSOS_QS_FULL 8'h03
`define TSOS_QS_LASTFLAG 8'h80

// fixed identification bits of the two sequence status bytes
`define TSOS_LASTSEQ_TAG 2'h1
`define TSOS_NEXTSEQ_TAG 2'h3

// timing: microsecond ticker derived from the 10 ns clock
`define TSOS_TICK_NS 1000
`define TSOS_CLK_NS 10
`define TSOS_TICK_CYC (`TSOS_TICK_NS / `TSOS_CLK_NS)
// prescaler end count: one hundred clocks per microsecond, counted from zero
`define TSOS_TICK_LAST 7'h63

`endif

//--- hw/dummy_unused_never.v
`default_nettype none
`default_nettype wire

//--- tb/tsos_props.sv
// checker for the output scheduler: status bytes, ticker, scan and channels
// assumes binding onto tsos_scheduler, one clock clk_i, sync reset rst_n_i
`default_nettype none
module tsos_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic commit_i,
    input wire logic busy_o,
    input wire logic [3:0] chan_o,
    input wire logic [7:0] last_seq_o,
    input wire logic [7:0] next_seq_o,
    input wire logic [7:0] queue_state_o,
    input wire logic [7:0] queue_count_o,
    input wire logic [31:0] ticker_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_seq_tag_bits: assert property (last_seq_o[7:6] == 2'h1 && next_seq_o[7:6] == 2'h3)
        else $error("sequence status tag bits wrong");
    a_state_code: assert property (queue_state_o[6:0] <= 7'h03)
        else $error("queue state code out of range");
    a_count_limit: assert property (queue_count_o <= 8'h1F)
        else $error("queue count above depth");
    // one microsecond is a hundred cycles, so a step is followed by calm
    a_ticker_step: assert property (!$stable(ticker_o) |->
        ticker_o == $past(ticker_o) + 32'h1 ##1 $stable(ticker_o)[*8])
        else $error("ticker stepped wrongly");
    a_ce_freeze: assert property (!ce_i |=> $stable(ticker_o) && $stable(chan_o))
        else $error("state moved with clock enable low");
    a_scan_start: assert property (ce_i && commit_i && !busy_o |=> busy_o)
        else $error("commit did not start a scan");
    a_scan_bound: assert property ($rose(busy_o) |-> ##[1:16] !busy_o)
        else $error("scan longer than fifteen slots");
    a_count_rise: assert property (queue_count_o > $past(queue_count_o) |->
        $past(busy_o) || $past(busy_o, 2) || $past(busy_o, 3))
        else $error("queue grew without a scan");
    a_chan_cause: assert property (!$stable(chan_o) |-> queue_count_o != 8'h00)
        else $error("channels changed with queue empty");
endmodule // tsos_props
bind tsos_scheduler tsos_props tsos_props_i (.clk_i, .rst_n_i, .ce_i, .commit_i, .busy_o,
    .chan_o, .last_seq_o, .next_seq_o, .queue_state_o, .queue_count_o, .ticker_o);
`default_nettype wire

//--- tb/tsos_writer.sv
// writer model: fills output image slots byte by byte, then commits
// assumes the scheduler samples on clk_i rising; busy_i is its busy_o
`default_nettype none
module tsos_writer (
    input wire logic clk_i,
    input wire logic busy_i,
    output logic wr_en_o,
    output logic [5:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic commit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en_o = 1'b0;
        wr_addr_o = 6'h3F;
        wr_data_o = 8'h00;
        commit_o = 1'b0;
    end
    // idle data toggles so a stale byte never passes for a fresh one
    task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wr_data_o <= ~d;
    endtask
    task automatic put(input logic [3:0] s, input logic [7:0] st, input logic [7:0] sq,
        input logic [15:0] t);
        wr_byte({s, 2'h0}, st);
        wr_byte({s, 2'h1}, sq);
        wr_byte({s, 2'h2}, t[7:0]);
        wr_byte({s, 2'h3}, t[15:8]);
    endtask
    // whole image handed over once; returns when status has settled
    task automatic commit();
        int n;
        @(posedge clk_i);
        commit_o <= 1'b1;
        @(posedge clk_i);
        commit_o <= 1'b0;
        n = 0;
        #1;
        while (busy_i === 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
        #1;
    endtask
endmodule // tsos_writer
`default_nettype wire

//--- tb/test_timestamped_output_scheduler.sv
// bench for the output scheduler: writer model drives, status checked
// assumes the design header on the include path and the checker bound
`default_nettype none
module test_timestamped_output_scheduler;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic run_i = 1'b0;
    logic large_area = 1'b1;
    logic wr_en, commit, busy;
    logic [5:0] wr_addr;
    logic [7:0] wr_data, last_seq, next_seq, q_state, q_count;
    logic [3:0] chan;
    logic [31:0] ticker;
    logic [15:0] tk;
    int n_fail = 0;
    int comparisons = 0;
    tsos_scheduler tsos_scheduler_i (.clk_i, .rst_n_i, .ce_i, .large_area_i(large_area), .run_i,
        .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .commit_i(commit),
        .busy_o(busy), .chan_o(chan), .last_seq_o(last_seq), .next_seq_o(next_seq),
        .queue_state_o(q_state), .queue_count_o(q_count), .ticker_o(ticker));
    tsos_writer tsos_writer_i (.clk_i, .busy_i(busy), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .commit_o(commit));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for the queue to drain to a given count
    task automatic wait_cnt(input logic [7:0] c);
        int n;
        n = 0;
        while (q_count !== c && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 10);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("last", 8'h40, last_seq);
        chk("next", 8'hC1, next_seq);
        chk("state", 8'h02, q_state);
        // clock enable pause longer than a microsecond
        @(posedge clk_i);
        ce_i <= 1'b0;
        @(posedge clk_i);
        #1;
        tk = ticker[15:0];
        repeat (300) @(posedge clk_i);
        chk("ticker", tk[7:0], ticker[7:0]);
        ce_i <= 1'b1;
        // two entries, second marked last; the junk slot after must be skipped
        tk = ticker[15:0] + 16'd5;
        tsos_writer_i.put(4'h0, 8'hA0, 8'h01, tk);
        tsos_writer_i.put(4'h1, 8'h50, 8'h42, tk + 16'd3);
        tsos_writer_i.put(4'h2, 8'hF0, 8'h03, tk + 16'd4);
        tsos_writer_i.commit();
        chk("last", 8'h42, last_seq);
        chk("count", 8'h02, q_count);
        chk("state", 8'h80, q_state);
        chk("next", 8'hC1, next_seq);
        wait_cnt(8'h01);
        chk("chan", 8'h0A, {4'h0, chan});
        wait_cnt(8'h00);
        chk("chan", 8'h05, {4'h0, chan});
        repeat (200) @(posedge clk_i);
        #1;
        chk("chan", 8'h05, {4'h0, chan});
        chk("state", 8'h00, q_state);
        chk("next", 8'hC3, next_seq);
        // out of sequence, then a repeat of the last accepted number
        tsos_writer_i.put(4'h0, 8'hA0, 8'h45, tk);
        tsos_writer_i.commit();
        chk("state", 8'h01, q_state);
        chk("last", 8'h42, last_seq);
        tsos_writer_i.put(4'h0, 8'hA0, 8'h42, tk);
        tsos_writer_i.commit();
        chk("state", 8'h02, q_state);
        // halt to run, resume with last plus one
        @(posedge clk_i);
        run_i <= 1'b1;
        tsos_writer_i.put(4'h0, 8'h30, 8'h03, tk + 16'd40000);
        tsos_writer_i.put(4'h1, 8'h30, 8'h00, tk + 16'd40000);
        tsos_writer_i.commit();
        chk("count", 8'h01, q_count);
        chk("next", 8'hC3, next_seq);
        chk("state", 8'h00, q_state);
        // two full areas fill the queue, one more is refused
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < 15; s++) begin
                tsos_writer_i.put(s[3:0], 8'h30, 8'(4 + k * 15 + s), tk + 16'd40000);
            end
            tsos_writer_i.commit();
        end
        chk("count", 8'h1F, q_count);
        tsos_writer_i.put(4'h0, 8'h30, 8'h62, tk + 16'd40000);
        tsos_writer_i.commit();
        chk("state", 8'h03, q_state);
        chk("count", 8'h1F, q_count);
        chk("last", 8'h61, last_seq);
        // mid-run reset into the 20-byte variant; slot 5 lies outside the area
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        run_i <= 1'b0;
        large_area <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("count", 8'h00, q_count);
        chk("last", 8'h40, last_seq);
        chk("ticker", 8'h00, ticker[7:0]);
        for (int s = 0; s < 6; s++) begin
            tsos_writer_i.put(s[3:0], 8'h30, 8'(s + 1), tk + 16'd40000);
        end
        tsos_writer_i.commit();
        chk("count", 8'h05, q_count);
        chk("last", 8'h45, last_seq);
        chk("state", 8'h00, q_state);
        conclude();
    end
endmodule // test_timestamped_output_scheduler
`default_nettype wire
